// file: hw/uart_irq_ident.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "uart_irq_defs.svh"

// Function
// RL1 - Pending sources rank line status, then receive data or timeout, then transmit empty, then modem status.
// RL2 - An identification read takes one frozen snapshot and later changes show only after the read.
// RL3 - Identification bits 7 and 6 both copy the FIFO enable bit.
// RL4 - Bits 3 to 1 give the top pending source, with bit 3 forced low outside FIFO mode.
// RL5 - Bit 0 is low while anything is pending, so an idle low nibble reads 0001.
// RL6 - Any line error flag gives code 0110 at top level until the line status register is read.
// RL7 - Data ready, or in FIFO mode a level at the trigger, gives code 0100 until drained.
// RL8 - In FIFO mode a non-empty idle receive FIFO for four character times gives code 1100 until read.
// RL9 - An empty transmit buffer gives code 0010 until an identification read shows it or a buffer write.
// RL10 - Any modem change flag gives code 0000 at lowest level until the modem status register is read.
// RL11 - The host line asserts for transmit empty only while its enable bit is set.
// RL12 - The trigger field picks 1, 4, 8 or 14 bytes for the receive threshold.
// RL13 - The host line drops one clock after no enabled source is pending, or after the identification read that holds it ends.
module uart_irq_ident #(
   parameter int LEVEL_W = `LEVEL_W_DEF,
   parameter int TIMEOUT_CHARS = `TIMEOUT_CHARS_DEF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [`ADDR_W-1:0] addr_i,
   input wire logic [`DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`DATA_W-1:0] rdata_o,
   // Line and modem status flags
   input wire uart_irq_pkg::line_errs_t line_errs_i,
   input wire uart_irq_pkg::modem_changes_t modem_changes_i,
   input wire logic rx_ready_flag_i,
   input wire logic tx_empty_flag_i,
   // Receive FIFO
   input wire logic [LEVEL_W-1:0] rx_level_i,
   input wire logic rx_push_i,
   input wire logic char_tick_i,
   // Host accesses elsewhere
   input wire uart_irq_pkg::host_access_t host_access_i,
   // Interrupts
   output logic host_irq_line_o,
   output logic evt_irq_o
);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   if (LEVEL_W < 4 || LEVEL_W > 8) begin : g_bad_level
      $error("LEVEL_W must be 4 to 8");
   end

   if (TIMEOUT_CHARS < 1 || TIMEOUT_CHARS > 255) begin : g_bad_timeout
      $error("TIMEOUT_CHARS must be 1 to 255");
   end

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   wire logic rd_ident = rd_i && (addr_i == `OFF_IDENT);
   wire logic wr_ctrl = wr_i && (addr_i == `OFF_CTRL);
   wire logic wr_ier = wr_i && (addr_i == `OFF_IER);
   wire logic wr_stat = wr_i && (addr_i == `OFF_EVT_STAT);
   wire logic wr_mask = wr_i && (addr_i == `OFF_EVT_MASK);

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [`DATA_W-1:0] ctrl_q;
   logic [`DATA_W-1:0] ctrl_d;
   logic [3:0] ier_q;
   logic [3:0] ier_d;
   logic [`EVT_W-1:0] mask_q;
   logic [`EVT_W-1:0] mask_d;

   assign ctrl_d = wr_ctrl ? wdata_i : ctrl_q;
   assign ier_d = wr_ier ? wdata_i[3:0] : ier_q;
   assign mask_d = wr_mask ? wdata_i[`EVT_W-1:0] : mask_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= `CTRL_RST;
         ier_q <= `IER_RST;
         mask_q <= `EVT_RST;
      end else begin
         ctrl_q <= ctrl_d;
         ier_q <= ier_d;
         mask_q <= mask_d;
      end
   end

   wire logic fifo_enable_bit = ctrl_q[`CTRL_FIFO_EN];
   wire logic [1:0] rx_trigger_field = ctrl_q[`CTRL_TRIG_HI:`CTRL_TRIG_LO];
   wire logic rx_avail_irq_enable = ier_q[`IER_RX];
   wire logic tx_empty_irq_enable = ier_q[`IER_TX];
   wire logic ls_irq_enable = ier_q[`IER_LS];
   wire logic ms_irq_enable = ier_q[`IER_MS];

   // ----------------------------------------
   // Receive trigger threshold
   // ----------------------------------------
   logic [7:0] trig_level;
   logic [7:0] rx_level_ext;

   assign trig_level = (rx_trigger_field == 2'b00) ? `TRIG_00 :
                       (rx_trigger_field == 2'b01) ? `TRIG_01 :
                       (rx_trigger_field == 2'b10) ? `TRIG_10 :
                       `TRIG_11; // see RL12
   assign rx_level_ext = 8'(rx_level_i);

   // ----------------------------------------
   // Edge history of incoming flags and the transmit empty enable bit
   // ----------------------------------------
   logic ls_any_q;
   logic ms_any_q;
   logic tx_flag_q;
   logic tx_en_q;

   wire logic ls_any = |line_errs_i;
   wire logic ms_any = |modem_changes_i;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ls_any_q <= 1'b0;
         ms_any_q <= 1'b0;
         tx_flag_q <= 1'b0;
         tx_en_q <= 1'b0;
      end else begin
         ls_any_q <= ls_any;
         ms_any_q <= ms_any;
         tx_flag_q <= tx_empty_flag_i;
         tx_en_q <= tx_empty_irq_enable;
      end
   end

   // ----------------------------------------
   // Source conditions
   // ----------------------------------------
   logic ls_q;
   logic ls_d;
   logic ms_q;
   logic ms_d;
   logic thre_q;
   logic thre_d;
   logic timeout;
   logic rda;

   wire logic ls_set = ls_any && !ls_any_q;
   wire logic ms_set = ms_any && !ms_any_q;
   wire logic tx_rise = tx_empty_flag_i && !tx_flag_q;
   wire logic tx_en_rise = tx_empty_irq_enable && !tx_en_q && tx_empty_flag_i;
   wire logic thre_set = tx_rise || tx_en_rise;

   // ----------------------------------------
   // Source sets held over an identification read
   // ----------------------------------------
   logic [2:0] defer_q;
   logic [2:0] defer_d;
   logic [2:0] raw_set;
   logic [2:0] eff_set;

   assign raw_set = {thre_set, ms_set, ls_set};
   assign defer_d = rd_ident ? (raw_set | defer_q) : '0;
   assign eff_set = rd_ident ? '0 : (raw_set | defer_q); // see RL2

   // Set wins over a clear in the same cycle
   assign ls_d = eff_set[0] || (ls_q && !host_access_i.line_status_read); // see RL6
   assign ms_d = eff_set[1] || (ms_q && !host_access_i.modem_status_read); // see RL10

   assign rda = fifo_enable_bit ? (rx_level_ext >= trig_level) : rx_ready_flag_i; // see RL7

   char_timeout_timer #(
      .TIMEOUT_CHARS(TIMEOUT_CHARS)
   ) u_timeout (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(fifo_enable_bit),
      .nonempty_i(rx_level_i != '0),
      .activity_i(rx_push_i || host_access_i.rx_buf_read),
      .char_tick_i(char_tick_i),
      .clear_i(host_access_i.rx_buf_read),
      .timeout_o(timeout)
   ); // see RL8

   // ----------------------------------------
   // Enabled pending sources
   // ----------------------------------------
   logic [`EVT_W-1:0] pend;

   assign pend[`EVT_LS] = ls_q && ls_irq_enable;
   assign pend[`EVT_RDA] = rda && rx_avail_irq_enable;
   assign pend[`EVT_TO] = timeout && rx_avail_irq_enable;
   assign pend[`EVT_THRE] = thre_q && tx_empty_irq_enable; // see RL11
   assign pend[`EVT_MS] = ms_q && ms_irq_enable;

   wire logic any_pend = |pend;

   // ----------------------------------------
   // Priority and identification byte
   // ----------------------------------------
   logic [3:0] code;
   logic [3:0] code_vis;
   logic [`DATA_W-1:0] ident_byte;

   assign code = pend[`EVT_LS] ? `CODE_LS :
                 pend[`EVT_RDA] ? `CODE_RDA :
                 pend[`EVT_TO] ? `CODE_TO :
                 pend[`EVT_THRE] ? `CODE_THRE :
                 pend[`EVT_MS] ? `CODE_MS :
                 `CODE_NONE; // see RL1 see RL5
   assign code_vis = {code[3] && fifo_enable_bit, code[2:0]}; // see RL4
   assign ident_byte = {fifo_enable_bit, fifo_enable_bit, 2'b00, code_vis}; // see RL3

   // ----------------------------------------
   // Transmit empty condition
   // ----------------------------------------
   wire logic ident_shows_thre = rd_ident && (code == `CODE_THRE);
   wire logic thre_clr = ident_shows_thre || host_access_i.tx_buf_write;

   assign thre_d = eff_set[2] || (thre_q && !thre_clr); // see RL9

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ls_q <= 1'b0;
         ms_q <= 1'b0;
         thre_q <= 1'b0;
         defer_q <= '0;
      end else begin
         ls_q <= ls_d;
         ms_q <= ms_d;
         thre_q <= thre_d;
         defer_q <= defer_d;
      end
   end

   // ----------------------------------------
   // Host interrupt line
   // ----------------------------------------
   logic host_irq_d;

   // Held through an identification read
   assign host_irq_d = rd_ident ? host_irq_line_o : any_pend; // see RL2 see RL13

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         host_irq_line_o <= 1'b0;
      end else begin
         host_irq_line_o <= host_irq_d;
      end
   end

   // ----------------------------------------
   // Sticky event status
   // ----------------------------------------
   logic [`EVT_W-1:0] pend_q;
   logic [`EVT_W-1:0] stat_q;
   logic [`EVT_W-1:0] stat_d;
   logic [`EVT_W-1:0] stat_clr;
   logic evt_irq_d;
   logic [`EVT_W-1:0] evt_set;

   // Per event bit, set wins over a write-one clear
   for (genvar b = 0; b < `EVT_W; b++) begin : g_evt
      assign evt_set[b] = pend[b] && !pend_q[b];
      assign stat_clr[b] = wr_stat && wdata_i[b];
      assign stat_d[b] = evt_set[b] || (stat_q[b] && !stat_clr[b]);
   end

   assign evt_irq_d = |(stat_d & mask_d);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q <= `EVT_RST;
         stat_q <= `EVT_RST;
         evt_irq_o <= 1'b0;
      end else begin
         pend_q <= pend;
         stat_q <= stat_d;
         evt_irq_o <= evt_irq_d;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [`DATA_W-1:0] rd_sel;
   logic [`DATA_W-1:0] rdata_d;

   // Snapshot of the identification byte taken in the read cycle
   always_comb begin
      rd_sel = 8'h00;
      if (addr_i == `OFF_IDENT) begin
         rd_sel = ident_byte; // see RL2
      end else if (addr_i == `OFF_CTRL) begin
         rd_sel = ctrl_q;
      end else if (addr_i == `OFF_IER) begin
         rd_sel = {4'h0, ier_q};
      end else if (addr_i == `OFF_EVT_STAT) begin
         rd_sel = {3'h0, stat_q};
      end else if (addr_i == `OFF_EVT_MASK) begin
         rd_sel = {3'h0, mask_q};
      end else if (addr_i == `OFF_PEND) begin
         rd_sel = {3'h0, pend};
      end
   end
   assign rdata_d = rd_i ? rd_sel : 8'h00;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rdata_d;
      end
   end

endmodule // uart_irq_ident

// file: common/uart_irq_defs.svh
`ifndef UART_IRQ_DEFS_SVH
`define UART_IRQ_DEFS_SVH

// ----------------------------------------
// Register port
// ----------------------------------------
`define ADDR_W 4
`define DATA_W 8
`define OFF_IDENT 4'h2
`define OFF_CTRL 4'h8
`define OFF_IER 4'h9
`define OFF_EVT_STAT 4'ha
`define OFF_EVT_MASK 4'hb
`define OFF_PEND 4'hc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_FIFO_EN 0
`define CTRL_TRIG_LO 6
`define CTRL_TRIG_HI 7
`define IER_RX 0
`define IER_TX 1
`define IER_LS 2
`define IER_MS 3
`define EVT_W 5
`define EVT_LS 0
`define EVT_RDA 1
`define EVT_TO 2
`define EVT_THRE 3
`define EVT_MS 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST 8'h00
`define IER_RST 4'h0
`define EVT_RST 5'h00

// ----------------------------------------
// Identification codes
// ----------------------------------------
`define CODE_NONE 4'h1
`define CODE_LS 4'h6
`define CODE_RDA 4'h4
`define CODE_TO 4'hc
`define CODE_THRE 4'h2
`define CODE_MS 4'h0

// ----------------------------------------
// Receive trigger levels and timeout
// ----------------------------------------
`define TRIG_00 8'h01
`define TRIG_01 8'h04
`define TRIG_10 8'h08
`define TRIG_11 8'h0e
`define LEVEL_W_DEF 5
`define TIMEOUT_CHARS_DEF 4

`endif

// file: common/uart_irq_pkg.sv
package uart_irq_pkg;

   // ----------------------------------------
   // Line status error flags
   // ----------------------------------------
   typedef struct packed {
      logic overrun;
      logic parity_error;
      logic framing_error;
      logic break_indication;
   } line_errs_t;

   // ----------------------------------------
   // Modem status change flags
   // ----------------------------------------
   typedef struct packed {
      logic clear_to_send_change;
      logic data_set_ready_change;
      logic ring_trailing_edge;
      logic carrier_detect_change;
   } modem_changes_t;

   // ----------------------------------------
   // Host accesses to neighbouring registers
   // ----------------------------------------
   typedef struct packed {
      logic line_status_read;
      logic modem_status_read;
      logic rx_buf_read;
      logic tx_buf_write;
   } host_access_t;

endpackage

// file: hw/char_timeout_timer.sv
`timescale 1ns/1ps

module char_timeout_timer #(
   parameter int TIMEOUT_CHARS = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Receive FIFO view
   input wire logic enable_i,
   input wire logic nonempty_i,
   input wire logic activity_i,
   input wire logic char_tick_i,
   input wire logic clear_i,
   // Result
   output logic timeout_o
);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   if (TIMEOUT_CHARS < 1 || TIMEOUT_CHARS > 255) begin : g_bad_chars
      $error("TIMEOUT_CHARS out of range");
   end

   localparam logic [7:0] LAST = 8'(TIMEOUT_CHARS - 1);

   // ----------------------------------------
   // Idle character counter
   // ----------------------------------------
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic timeout_d;
   wire logic idle_run = enable_i && nonempty_i && !activity_i;
   wire logic expire = idle_run && char_tick_i && (cnt_q == LAST);

   assign cnt_d = !idle_run ? 8'h00 : (char_tick_i && cnt_q != LAST) ? cnt_q + 8'h01 : cnt_q;
   assign timeout_d = (expire || timeout_o) && !clear_i && enable_i; // see RL8

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 8'h00;
         timeout_o <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         timeout_o <= timeout_d;
      end
   end

endmodule // char_timeout_timer

// file: test/uart_irq_ident_properties.sv
`timescale 1ns/1ps

module uart_irq_ident_properties (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Status and interrupt
   input wire logic tx_empty_flag_i,
   input wire logic host_irq_line_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   wire id_rd = rd_i && addr_i == 4'h2;

   // ----------------------------------------
   // Read data and identification read checks
   // ----------------------------------------
   a_rdata_one_cycle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read answer");
   a_ident_mode_copy: assert property (id_rd |=> rdata_o[7] == rdata_o[6])
      else $error("mode bits differ");
   a_ident_spare_zero: assert property (id_rd |=> rdata_o[5:4] == 2'h0)
      else $error("spare bits set");
   a_ident_bit3_mode: assert property (id_rd ##1 !rdata_o[7] |-> !rdata_o[3])
      else $error("bit 3 set outside fifo mode");
   a_ident_idle_code: assert property (id_rd ##1 rdata_o[0] |-> rdata_o[3:1] == 3'h0)
      else $error("idle with source code");
   a_ident_code_legal: assert property (id_rd |=> rdata_o[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
      else $error("illegal source code");
   a_irq_read_freeze: assert property (id_rd |=> $stable(host_irq_line_o))
      else $error("host line moved during read");
   a_thre_read_clear: assert property ((id_rd && tx_empty_flag_i) ##1 (rdata_o[3:0] == 4'h2 && !rd_i && !wr_i &&
      tx_empty_flag_i) ##1 (id_rd && tx_empty_flag_i) |=> rdata_o[3:0] != 4'h2)
      else $error("tx empty shown twice");
endmodule // uart_irq_ident_properties

bind uart_irq_ident uart_irq_ident_properties u_props (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .addr_i(addr_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .tx_empty_flag_i(tx_empty_flag_i),
   .host_irq_line_o(host_irq_line_o)
);

// file: test/serial_side_model.sv
`timescale 1ns/1ps

module serial_side_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bench commands
   input wire uart_irq_pkg::line_errs_t err_set_i,
   input wire uart_irq_pkg::modem_changes_t mdm_set_i,
   input wire logic push_i,
   input wire logic tx_done_i,
   input wire uart_irq_pkg::host_access_t acc_i,
   // Status towards the block
   output uart_irq_pkg::line_errs_t line_errs_o,
   output uart_irq_pkg::modem_changes_t modem_changes_o,
   output logic rx_ready_o,
   output logic tx_empty_o,
   output logic [4:0] rx_level_o,
   output logic rx_push_o,
   output logic char_tick_o
);
   logic [5:0] tick_q;

   assign rx_ready_o = rx_level_o != 5'h00;
   assign char_tick_o = tick_q == 6'h3f;

   // ----------------------------------------
   // Status flags, cleared by their reads; transmit empty is cleared by a buffer write
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_errs_o <= '0;
         modem_changes_o <= '0;
         tx_empty_o <= 1'b0;
         rx_level_o <= 5'h00;
         rx_push_o <= 1'b0;
         tick_q <= 6'h00;
      end else begin
         line_errs_o <= acc_i.line_status_read ? err_set_i : line_errs_o | err_set_i;
         modem_changes_o <= acc_i.modem_status_read ? mdm_set_i : modem_changes_o | mdm_set_i;
         tx_empty_o <= tx_done_i | (tx_empty_o & !acc_i.tx_buf_write);
         rx_level_o <= rx_level_o + {4'h0, push_i} - {4'h0, acc_i.rx_buf_read};
         rx_push_o <= push_i;
         tick_q <= tick_q + 6'h01;
      end
   end
endmodule // serial_side_model

// file: test/uart_interrupt_identifier_bench.sv
`timescale 1ns/1ps
`include "uart_irq_defs.svh"

`define CHK(what, exp, got) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("MISMATCH %s exp %h got %h", what, exp, got); \
   end \
end

module uart_interrupt_identifier_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [13:0] cmd = 14'h0000;
   logic [7:0] rdata;
   logic irq;
   logic evt_irq;
   uart_irq_pkg::line_errs_t errs;
   uart_irq_pkg::modem_changes_t mdm;
   logic rx_rdy;
   logic tx_emp;
   logic [4:0] level;
   logic rx_push;
   logic tick;
   int error_cnt = 0;
   int checks = 0;
   localparam logic [13:0] txd = 14'h0001, psh = 14'h0002, txw = 14'h0004, rxr = 14'h0008;
   localparam logic [13:0] mdm_rd = 14'h0010, ls_rd = 14'h0020, mdm_ev = 14'h0040, err_ev = 14'h0400;
   localparam logic [7:0] trig [4] = '{`TRIG_00, `TRIG_01, `TRIG_10, `TRIG_11};

   always #50 clk = ~clk;

   serial_side_model far (
      .clk_i(clk), .rst_n_i(rst_n), .err_set_i(cmd[13:10]), .mdm_set_i(cmd[9:6]), .push_i(cmd[1]),
      .tx_done_i(cmd[0]), .acc_i(cmd[5:2]), .line_errs_o(errs), .modem_changes_o(mdm), .rx_ready_o(rx_rdy),
      .tx_empty_o(tx_emp), .rx_level_o(level), .rx_push_o(rx_push), .char_tick_o(tick));

   uart_irq_ident dut (
      .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .line_errs_i(errs), .modem_changes_i(mdm), .rx_ready_flag_i(rx_rdy), .tx_empty_flag_i(tx_emp),
      .rx_level_i(level), .rx_push_i(rx_push), .char_tick_i(tick), .host_access_i(cmd[5:2]),
      .host_irq_line_o(irq), .evt_irq_o(evt_irq));

   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      `CHK("rdata", exp, d)
   endtask

   task automatic pulse(input logic [13:0] v);
      @(posedge clk);
      cmd <= v;
      @(posedge clk);
      cmd <= 14'h0000;
   endtask

   task automatic irq_is(input logic e);
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK("host_irq", e, irq)
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_state();
      rd_chk(`OFF_IDENT, 8'h01);
      rd_chk(4'h5, 8'h00);
      wr_reg(`OFF_IDENT, 8'hff);
      rd_chk(`OFF_IDENT, 8'h01);
      irq_is(1'b0);
   endtask

   task automatic t_priority();
      wr_reg(`OFF_IER, 8'h0f);
      rd_chk(`OFF_IER, 8'h0f);
      wr_reg(`OFF_EVT_MASK, 8'h10);
      pulse(mdm_ev);
      rd_chk(`OFF_IDENT, 8'h00);
      irq_is(1'b1);
      pulse(txd);
      rd_chk(`OFF_IDENT, 8'h02);
      rd_chk(`OFF_IDENT, 8'h00);
      pulse(err_ev);
      rd_chk(`OFF_IDENT, 8'h06);
      rd_chk(`OFF_PEND, 8'h11);
      rd_chk(`OFF_EVT_STAT, 8'h19);
      `CHK("evt_irq", 1'b1, evt_irq)
      wr_reg(`OFF_EVT_STAT, 8'h10);
      rd_chk(`OFF_EVT_STAT, 8'h09);
      irq_is(1'b1);
      `CHK("evt_irq", 1'b0, evt_irq)
      pulse(ls_rd);
      rd_chk(`OFF_IDENT, 8'h00);
      pulse(mdm_rd);
      rd_chk(`OFF_IDENT, 8'h01);
      irq_is(1'b0);
   endtask

   task automatic t_tx_enable();
      wr_reg(`OFF_IER, 8'h00);
      pulse(txw);
      pulse(txd);
      irq_is(1'b0);
      rd_chk(`OFF_IDENT, 8'h01);
      wr_reg(`OFF_IER, 8'h02);
      irq_is(1'b1);
      pulse(txw);
      irq_is(1'b0);
   endtask

   task automatic t_fifo_trigger();
      wr_reg(`OFF_IER, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`OFF_CTRL, {i[1:0], 6'h01});
         repeat (int'(trig[i]) - 1) pulse(psh);
         rd_chk(`OFF_IDENT, 8'hc1);
         pulse(psh);
         rd_chk(`OFF_IDENT, 8'hc4);
         irq_is(1'b1);
         repeat (int'(trig[i])) pulse(rxr);
         rd_chk(`OFF_IDENT, 8'hc1);
      end
   endtask

   task automatic t_timeout();
      logic [7:0] got;
      wr_reg(`OFF_CTRL, 8'h41);
      pulse(psh);
      rd_chk(`OFF_IDENT, 8'hc1);
      got = 8'h00;
      for (int i = 0; i < 20 && got !== 8'hcc; i++) begin
         repeat (40) @(posedge clk);
         rd_reg(`OFF_IDENT, got);
      end
      `CHK("timeout", 8'hcc, got)
      if (got !== 8'hcc) print_verdict();
      pulse(rxr);
      rd_chk(`OFF_IDENT, 8'hc1);
      wr_reg(`OFF_CTRL, 8'h00);
      pulse(psh);
      rd_chk(`OFF_IDENT, 8'h04);
      pulse(rxr);
      rd_chk(`OFF_IDENT, 8'h01);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_state();
      t_priority();
      t_tx_enable();
      t_fifo_trigger();
      t_timeout();
      print_verdict();
   end
endmodule // uart_interrupt_identifier_bench
